// ---- hdl/operating_mode_control.sv ----
// Operating mode control: mode pin capture, mode register on APB,
// port usage, bus clock stretch, visibility and debug map placement.
// Assumes mode pins are asynchronous; debug and CPU strobes are on mclk.
//
// Functional notes
// [RQ1] Mode pins captured at reset release into mode bits, which show mode.
// [RQ2] Pin code decodes to seven modes; reserved code forced to peripheral.
// [RQ3] Single-chip modes: no external bus, ports A and B are GPIO.
// [RQ4] Wide and peripheral modes: A and B form 16-bit muxed bus.
// [RQ5] Narrow modes: address on A and B, data only on port A.
// [RQ6] Narrow 16-bit transfer: high byte, then low byte at address plus one.
// [RQ7] Normal modes protect bits; special modes allow wider writes. Here wait-stop is written in normal modes only.
// [RQ8] Special single-chip enters active debug out of reset; else enable first.
// [RQ9] Enabled debug activates on serial command or halt-to-debug instruction.
// [RQ10] Active debug maps ROM at FF20-FFFF and registers at FF00-FF06.
// [RQ11] Active debug hides user memory of top page from normal accesses.
// [RQ12] Peripheral mode holds processor idle; debug unused; reset-only.
// [RQ13] Mode register absent from the map in peripheral mode.
// [RQ14] Special-mode bit readable; writable in special modes except first write.
// [RQ15] Mode selects: once in normal, special except first; never 10.
// [RQ16] Stretch enable 0: free clock; 1: stretch external and hidden cycles.
// [RQ17] Stretch enable reads 1 in expanded modes.
// [RQ18] Stretch enable: once in normal modes, anytime in special modes.
// [RQ19] Visibility in expanded modes shows internal accesses; never single-chip.
// [RQ20] Special narrow with visibility shows internal data wide on A and B.
// [RQ21] Visibility bit: once in normal, special except first write.
// [RQ22] Wait-stop bit shuts external bus in wait after activity completes.
// [RQ23] Port E emulation in expanded modes unmaps port E registers.
// [RQ24] Reset loads stretch 1, wait-stop 0, visibility and emulation by mode.
// [RQ25] Unused bit 1 reads 0 and ignores writes.
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module operating_mode_control (
  input wire logic mclk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode pins
  input wire logic debug_pin,
  input wire logic mode_select_upper_pin,
  input wire logic mode_select_lower_pin,
  // Debug and processor events
  input wire logic debug_enable_cmd,
  input wire logic debug_serial_cmd,
  input wire logic halt_to_debug_instruction,
  input wire logic debug_exit,
  input wire logic wait_mode,
  // CPU access under way
  input wire logic cpu_access,
  input wire logic cpu_external,
  input wire logic [15:0] cpu_addr,
  // External transfer request
  input wire logic ext_req,
  input wire logic ext_word,
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_wdata,
  // Mode and port configuration
  output logic special_mode_low,
  output logic mode_select_upper,
  output logic mode_select_lower,
  output logic mode_valid,
  output logic port_a_gpio,
  output logic port_b_gpio,
  output logic port_b_addr_only,
  output logic cpu_hold,
  output logic port_e_mapped,
  output logic ext_bus_off,
  // Bus clock and visibility
  output logic stretch_high,
  output logic stretch_low,
  output logic visible_cycle,
  output logic visible_wide,
  // Background debug
  output logic background_debug_enabled,
  output logic background_debug_active,
  output logic debug_rom_sel,
  output logic debug_reg_sel,
  output logic user_top_hidden,
  // External bus cycles
  output logic bus_valid,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_data,
  output logic bus_high,
  output logic bus_done
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;
  logic [1:0] cap_cnt;
  logic capture;
  logic [2:0] cap_code;
  logic bus_clock_stretch_enable;
  logic internal_bus_visible;
  logic ext_bus_wait_stop;
  logic port_e_emulation;
  logic wr_seen;
  logic special;
  logic expanded;
  logic narrow;
  logic single_chip;
  logic peripheral;
  logic stretch_eff;
  logic setup;
  logic hit;
  logic wr_en;
  logic first;
  logic once_ok;
  logic [2:0] req_code;
  logic [7:0] read_value;
  logic seq_busy;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  assign special = ~special_mode_low;
  assign single_chip = ~mode_select_upper & ~mode_select_lower; // RQ2
  assign expanded = mode_select_lower; // RQ2
  assign narrow = ~mode_select_upper & mode_select_lower; // RQ2
  assign peripheral = {special_mode_low, mode_select_upper,
                       mode_select_lower} == opmode_pkg::MODE_PERIPHERAL;
  assign stretch_eff = bus_clock_stretch_enable | expanded; // RQ17

  // ----------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin_in({debug_pin, mode_select_upper_pin, mode_select_lower_pin}),
    .pin_sync_out(pins_sync)
  );

  assign capture = !mode_valid && cap_cnt == opmode_pkg::CAPTURE_DELAY;
  assign cap_code = (pins_sync == opmode_pkg::MODE_RESERVED) ?
                    opmode_pkg::MODE_PERIPHERAL : pins_sync; // RQ2

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cap_cnt <= 2'h0;
      mode_valid <= 1'b0;
    end else if (!mode_valid) begin
      if (capture) begin
        mode_valid <= 1'b1;
      end else begin
        cap_cnt <= cap_cnt + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------
  assign setup = psel & ~penable;
  assign hit = paddr == opmode_pkg::MODE_REG_ADDR;
  assign wr_en = psel & penable & pready & pwrite & hit & ~peripheral
                 & mode_valid; // RQ13
  assign first = ~wr_seen;
  assign once_ok = special ? ~first : first; // RQ7

  always_comb begin
    req_code = {special_mode_low, mode_select_upper, mode_select_lower};
    if (special && !first) begin
      req_code[2] = pwdata[opmode_pkg::BIT_SPECIAL_LOW]; // RQ14
    end
    if (once_ok && pwdata[opmode_pkg::BIT_SEL_UPPER -: 2] !=
        opmode_pkg::SEL_FORBIDDEN) begin
      req_code[1:0] = pwdata[opmode_pkg::BIT_SEL_UPPER -: 2]; // RQ15
    end
  end

  always_comb begin
    read_value = 8'h00; // RQ25
    read_value[opmode_pkg::BIT_SPECIAL_LOW] = special_mode_low; // RQ14
    read_value[opmode_pkg::BIT_SEL_UPPER] = mode_select_upper; // RQ1
    read_value[opmode_pkg::BIT_SEL_LOWER] = mode_select_lower;
    read_value[opmode_pkg::BIT_STRETCH] = stretch_eff; // RQ17
    read_value[opmode_pkg::BIT_VISIBLE] = internal_bus_visible;
    read_value[opmode_pkg::BIT_WAIT_STOP] = ext_bus_wait_stop;
    read_value[opmode_pkg::BIT_PORT_E_EMU] = port_e_emulation;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & (~hit | peripheral); // RQ13
      if (setup) begin
        prdata <= (hit && !peripheral) ? {24'h00_0000, read_value}
                                       : 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {special_mode_low, mode_select_upper, mode_select_lower} <=
        opmode_pkg::MODE_RESET_DEFAULT;
      bus_clock_stretch_enable <= opmode_pkg::STRETCH_RESET;
      internal_bus_visible <= 1'b0;
      ext_bus_wait_stop <= opmode_pkg::WAIT_STOP_RESET;
      port_e_emulation <= 1'b0;
      wr_seen <= 1'b0;
    end else if (capture) begin
      {special_mode_low, mode_select_upper, mode_select_lower} <=
        cap_code; // RQ1
      bus_clock_stretch_enable <= opmode_pkg::STRETCH_RESET; // RQ24
      ext_bus_wait_stop <= opmode_pkg::WAIT_STOP_RESET; // RQ24
      internal_bus_visible <= ~cap_code[2]; // RQ24
      port_e_emulation <= ~cap_code[2]; // RQ24
    end else if (wr_en) begin
      wr_seen <= 1'b1;
      {special_mode_low, mode_select_upper, mode_select_lower} <=
        req_code; // RQ15
      if (special || first) begin
        bus_clock_stretch_enable <= pwdata[opmode_pkg::BIT_STRETCH]; // RQ18
      end
      if (once_ok) begin
        internal_bus_visible <= pwdata[opmode_pkg::BIT_VISIBLE]; // RQ21
        port_e_emulation <= pwdata[opmode_pkg::BIT_PORT_E_EMU]; // RQ7
      end
      if (!special) begin
        ext_bus_wait_stop <= pwdata[opmode_pkg::BIT_WAIT_STOP]; // RQ7
      end
    end
  end

  // ----------------------------------------------------------------
  // Port usage
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_gpio <= 1'b1;
      port_b_gpio <= 1'b1;
      port_b_addr_only <= 1'b0;
      cpu_hold <= 1'b1;
      port_e_mapped <= 1'b1;
    end else begin
      port_a_gpio <= single_chip; // RQ3
      port_b_gpio <= single_chip; // RQ3
      port_b_addr_only <= narrow; // RQ5
      cpu_hold <= ~mode_valid | peripheral; // RQ12
      port_e_mapped <= ~peripheral & ~(expanded & port_e_emulation); // RQ23
    end
  end

  // ----------------------------------------------------------------
  // Bus clock and visibility
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stretch_high <= 1'b0;
      stretch_low <= 1'b0;
      visible_cycle <= 1'b0;
      visible_wide <= 1'b0;
    end else begin
      stretch_high <= stretch_eff & cpu_access & cpu_external; // RQ16
      stretch_low <= stretch_eff & cpu_access & ~cpu_external
                     & ~(expanded & internal_bus_visible); // RQ16
      visible_cycle <= expanded & internal_bus_visible & cpu_access
                       & ~cpu_external; // RQ19
      visible_wide <= narrow & special & internal_bus_visible & cpu_access
                      & ~cpu_external; // RQ20
    end
  end

  // ----------------------------------------------------------------
  // Wait-mode bus shutdown
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ext_bus_off <= 1'b0;
    end else begin
      ext_bus_off <= ext_bus_wait_stop & wait_mode & ~seq_busy; // RQ22
    end
  end

  // ----------------------------------------------------------------
  // Background debug
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      background_debug_enabled <= 1'b0;
      background_debug_active <= 1'b0;
    end else if (capture) begin
      background_debug_enabled <=
        cap_code == opmode_pkg::MODE_SPECIAL_SINGLE; // RQ8
      background_debug_active <=
        cap_code == opmode_pkg::MODE_SPECIAL_SINGLE; // RQ8
    end else begin
      if (debug_enable_cmd) begin
        background_debug_enabled <= 1'b1;
      end
      if (background_debug_enabled && !peripheral
          && (debug_serial_cmd || halt_to_debug_instruction)) begin
        background_debug_active <= 1'b1; // RQ9
      end else if (debug_exit) begin
        background_debug_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      debug_rom_sel <= 1'b0;
      debug_reg_sel <= 1'b0;
      user_top_hidden <= 1'b0;
    end else begin
      debug_rom_sel <= background_debug_active & cpu_access
                       & cpu_addr >= opmode_pkg::DEBUG_ROM_LOW; // RQ10
      debug_reg_sel <= background_debug_active & cpu_access
                       & cpu_addr >= opmode_pkg::DEBUG_REG_LOW
                       & cpu_addr <= opmode_pkg::DEBUG_REG_HIGH; // RQ10
      user_top_hidden <= background_debug_active & cpu_access
                         & cpu_addr[15:8] == opmode_pkg::TOP_PAGE; // RQ11
    end
  end

  // ----------------------------------------------------------------
  // External bus cycles
  // ----------------------------------------------------------------
  ext_bus_seq u_ext_bus_seq (
    .mclk(mclk),
    .arst_n(arst_n),
    .enable((expanded | peripheral) & ~ext_bus_off), // RQ3
    .narrow(narrow),
    .req(ext_req),
    .word(ext_word),
    .addr(ext_addr),
    .wdata(ext_wdata),
    .bus_valid(bus_valid),
    .bus_addr(bus_addr),
    .bus_data(bus_data),
    .bus_high(bus_high),
    .busy(seq_busy),
    .done(bus_done)
  );

endmodule : operating_mode_control
`default_nettype wire

// ---- hdl/opmode_pkg.sv ----
// Constants, field layout and state encodings for the operating mode block.
// Assumes a single 50 MHz system clock and a 32-bit APB register port.
package opmode_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_REG_INDEX = 8'h0b;
  localparam logic [11:0] MODE_REG_ADDR = {2'h0, MODE_REG_INDEX, 2'h0};

  // Field positions in the mode register
  localparam int unsigned BIT_SPECIAL_LOW = 7;
  localparam int unsigned BIT_SEL_UPPER = 6;
  localparam int unsigned BIT_SEL_LOWER = 5;
  localparam int unsigned BIT_STRETCH = 4;
  localparam int unsigned BIT_VISIBLE = 3;
  localparam int unsigned BIT_WAIT_STOP = 2;
  localparam int unsigned BIT_PORT_E_EMU = 0;

  // ----------------------------------------------------------------
  // Mode codes {special_mode_low, mode_select_upper, mode_select_lower}
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_RESET_DEFAULT = 3'h4;
  localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
  localparam logic [2:0] MODE_PERIPHERAL = 3'h2;
  localparam logic [2:0] MODE_RESERVED = 3'h6;
  localparam logic [1:0] SEL_FORBIDDEN = 2'h2;

  localparam logic STRETCH_RESET = 1'b1;
  localparam logic WAIT_STOP_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Background debug map
  // ----------------------------------------------------------------
  localparam logic [15:0] DEBUG_ROM_LOW = 16'hff20;
  localparam logic [15:0] DEBUG_REG_LOW = 16'hff00;
  localparam logic [15:0] DEBUG_REG_HIGH = 16'hff06;
  localparam logic [7:0] TOP_PAGE = 8'hff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [1:0] CAPTURE_DELAY = 2'h2;
  localparam logic [15:0] ADDR_STEP = 16'h0001;

  // External bus sequencer states, Gray along idle-high-low
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_HIGH = 2'b01,
    BUS_LOW = 2'b11,
    BUS_SINGLE = 2'b10
  } bus_state_t;

endpackage : opmode_pkg

// ---- hdl/pin_sync.sv ----
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static around reset release.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          stage1[i] <= 1'b0;
          pin_sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= pin_in[i];
          pin_sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync
`default_nettype wire

// ---- hdl/ext_bus_seq.sv ----
// External multiplexed bus sequencer: one cycle on a wide bus,
// two byte cycles for a word transfer on a narrow bus.
// Assumes requests come from logic on mclk and are held one cycle.
`timescale 1ns/1ns
`default_nettype none
module ext_bus_seq (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic narrow,
  input wire logic req,
  input wire logic word,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output logic bus_valid,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_data,
  output logic bus_high,
  output logic busy,
  output logic done
);

  opmode_pkg::bus_state_t state;
  logic [7:0] low_byte;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= opmode_pkg::BUS_IDLE;
      bus_valid <= 1'b0;
      bus_addr <= 16'h0000;
      bus_data <= 16'h0000;
      bus_high <= 1'b0;
      low_byte <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      bus_valid <= 1'b0;
      done <= 1'b0;
      case (state)
        opmode_pkg::BUS_IDLE: begin
          if (req && enable) begin
            bus_valid <= 1'b1;
            bus_addr <= addr;
            busy <= 1'b1;
            low_byte <= wdata[7:0];
            if (narrow && word) begin
              state <= opmode_pkg::BUS_HIGH; // RQ6
              bus_data <= {8'h00, wdata[15:8]}; // RQ5
              bus_high <= 1'b1;
            end else begin
              state <= opmode_pkg::BUS_SINGLE;
              bus_data <= narrow ? {8'h00, wdata[7:0]} : wdata; // RQ4
              bus_high <= ~narrow;
            end
          end
        end
        opmode_pkg::BUS_HIGH: begin
          state <= opmode_pkg::BUS_LOW;
          bus_valid <= 1'b1;
          bus_addr <= bus_addr + opmode_pkg::ADDR_STEP; // RQ6
          bus_data <= {8'h00, low_byte};
          bus_high <= 1'b0;
        end
        opmode_pkg::BUS_LOW, opmode_pkg::BUS_SINGLE: begin
          state <= opmode_pkg::BUS_IDLE;
          busy <= 1'b0;
          done <= 1'b1;
        end
        default: begin
          state <= opmode_pkg::BUS_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

endmodule : ext_bus_seq
`default_nettype wire

// ---- verification/operating_mode_control_sva.sv ----
// Checker for the operating mode block, watching its top ports only.
// Assumes one clock, mclk, and the asynchronous active-low arst_n.
`timescale 1ns/1ns
`default_nettype none
module operating_mode_control_sva (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic halt_to_debug_instruction,
  input wire logic cpu_access,
  input wire logic cpu_external,
  input wire logic [15:0] cpu_addr,
  input wire logic special_mode_low,
  input wire logic mode_select_upper,
  input wire logic mode_select_lower,
  input wire logic mode_valid,
  input wire logic port_a_gpio,
  input wire logic port_b_gpio,
  input wire logic port_b_addr_only,
  input wire logic cpu_hold,
  input wire logic stretch_high,
  input wire logic background_debug_enabled,
  input wire logic background_debug_active,
  input wire logic debug_rom_sel,
  input wire logic user_top_hidden,
  input wire logic bus_valid,
  input wire logic [15:0] bus_addr,
  input wire logic bus_high
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic dbg_access;
  logic periph;
  assign dbg_access = background_debug_active && cpu_access;
  assign periph = !special_mode_low && mode_select_upper && !mode_select_lower;

  a_periph_refused: assert property (
    psel && penable && pready && periph |-> pslverr)
    else $error("periph access not refused");
  a_sel_forbidden: assert property (
    mode_valid && special_mode_low
    |-> !(mode_select_upper && !mode_select_lower))
    else $error("forbidden select code");
  a_rom_map: assert property (
    dbg_access && cpu_addr >= 16'hff20 |=> debug_rom_sel)
    else $error("debug rom not selected");
  a_top_hidden: assert property (
    dbg_access && cpu_addr[15:8] == 8'hff |=> user_top_hidden)
    else $error("top page not hidden");
  a_single_gpio: assert property (
    mode_valid && !mode_select_upper && !mode_select_lower
    |=> port_a_gpio && port_b_gpio) else $error("single chip ports not gpio");
  a_narrow_ports: assert property (
    mode_valid && !mode_select_upper && mode_select_lower
    |=> port_b_addr_only) else $error("narrow port b not address only");
  a_periph_hold: assert property (
    mode_valid && periph |=> cpu_hold) else $error("processor not held");
  a_ext_stretch: assert property (
    mode_valid && mode_select_lower && cpu_access && cpu_external
    |=> stretch_high) else $error("external cycle not stretched");
  a_halt_debug: assert property (
    background_debug_enabled && !cpu_hold && halt_to_debug_instruction
    |=> background_debug_active) else $error("halt did not enter debug");
  a_narrow_split: assert property (
    bus_valid && bus_high && port_b_addr_only |=> bus_valid && !bus_high
    && bus_addr == $past(bus_addr) + 16'h1) else $error("low byte cycle bad");
endmodule : operating_mode_control_sva

bind operating_mode_control operating_mode_control_sva u_sva (.*);
`default_nettype wire

// ---- verification/ext_bus_partner.sv ----
// Memory on the far side of the multiplexed bus; logs both byte cycles.
// Assumes byte data rides on bus_data[7:0] in narrow transfers.
`timescale 1ns/1ns
`default_nettype none
module ext_bus_partner (
  input wire logic mclk,
  input wire logic bus_valid,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_data,
  input wire logic bus_high,
  output logic [15:0] hi_addr,
  output logic [7:0] hi_data,
  output logic [15:0] lo_addr,
  output logic [7:0] lo_data
);
  // Latch each byte cycle
  always_ff @(posedge mclk) begin
    if (bus_valid && bus_high) begin
      hi_addr <= bus_addr;
      hi_data <= bus_data[7:0];
    end else if (bus_valid) begin
      lo_addr <= bus_addr;
      lo_data <= bus_data[7:0];
    end
  end
endmodule : ext_bus_partner
`default_nettype wire

// ---- verification/operating_mode_control_test.sv ----
// Self-checking bench for the operating mode block.
// Assumes package, checker and partner compiled first.
`timescale 1ns/1ns
`default_nettype none
module operating_mode_control_test;
  logic mclk, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] pins = 3'h4;
  logic [3:0] ev = 4'h0;
  logic wait_mode = 1'b0, cpu_access = 1'b0, cpu_external = 1'b0;
  logic ext_req = 1'b0, ext_word = 1'b0, pready, pslverr, err;
  logic [15:0] cpu_addr = 16'h0, ext_addr = 16'h0, ext_wdata = 16'h0;
  logic [15:0] bus_addr, bus_data, hi_addr, lo_addr;
  logic [7:0] hi_data, lo_data;
  logic special_mode_low, mode_select_upper, mode_select_lower, mode_valid;
  logic port_a_gpio, port_b_gpio, port_b_addr_only, cpu_hold, ext_bus_off;
  logic visible_cycle, background_debug_enabled, background_debug_active;
  logic debug_rom_sel, debug_reg_sel, user_top_hidden;
  logic bus_valid, bus_high, bus_done;
  logic port_e_mapped, stretch_low, visible_wide;
  int n_mismatch = 0;
  int n_checks = 0;
  localparam logic [11:0] A = opmode_pkg::MODE_REG_ADDR;

  operating_mode_control dut (.*, .debug_pin(pins[2]),
    .mode_select_upper_pin(pins[1]), .mode_select_lower_pin(pins[0]),
    .debug_enable_cmd(ev[0]), .debug_serial_cmd(ev[1]),
    .halt_to_debug_instruction(ev[2]), .debug_exit(ev[3]), .stretch_high());
  ext_bus_partner mem (.*);

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // ----------
  // Shared tasks
  // ----------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic hang();
    n_mismatch++;
    end_sim();
  endtask : hang

  // Reset, then wait for capture
  task automatic boot(input logic [2:0] p);
    int n;
    arst_n <= 1'b0;
    pins <= p;
    cyc(16);
    arst_n <= 1'b1;
    for (n = 0; n < 20 && mode_valid !== 1'b1; n++) cyc(1);
    if (n == 20) hang();
    cyc(2);
  endtask : boot

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    cyc(1);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    cyc(1);
    penable <= 1'b1;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) hang();
  endtask : apb

  task automatic rdchk(input logic [7:0] e);
    apb(1'b0, A, 8'h00);
    chk(rd, {24'h0, e});
    chk(err, 1'b0);
  endtask : rdchk

  task automatic acc(input logic [15:0] a, input logic x);
    cpu_access <= 1'b1;
    cpu_external <= x;
    cpu_addr <= a;
    cyc(1);
    cpu_access <= 1'b0;
    cyc(1);
  endtask : acc

  task automatic pulse(input logic [3:0] m);
    ev <= m;
    cyc(1);
    ev <= 4'h0;
    cyc(2);
  endtask : pulse

  task automatic xfer(input logic [15:0] a, input logic [15:0] d);
    int n;
    ext_req <= 1'b1;
    ext_word <= 1'b1;
    ext_addr <= a;
    ext_wdata <= d;
    cyc(1);
    ext_req <= 1'b0;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (bus_done !== 1'b1 && n < 20);
    if (n == 20) hang();
  endtask : xfer

  // ----------
  // Scenarios
  // ----------
  task automatic narrow_normal();
    boot(3'b101);
    rdchk(8'hb0);
    chk({port_b_addr_only, port_a_gpio}, 2'b10);
    xfer(16'h12ff, 16'habcd);
    chk({hi_addr, hi_data}, 24'h12ffab);
    chk({lo_addr, lo_data}, 24'h1300cd);
    acc(16'h4000, 1'b1);
    apb(1'b1, A, 8'hff);
    rdchk(8'hfd);
    acc(16'h0800, 1'b0);
    chk(visible_cycle, 1'b1);
    wait_mode <= 1'b1;
    cyc(3);
    chk(ext_bus_off, 1'b1);
    wait_mode <= 1'b0;
    apb(1'b1, A, 8'h80);
    rdchk(8'hf9);
    apb(1'b0, 12'h030, 8'h00);
    chk(err, 1'b1);
  endtask : narrow_normal

  task automatic special_single();
    boot(3'b000);
    rdchk(8'h19);
    chk({background_debug_active, port_a_gpio, port_b_gpio}, 3'h7);
    acc(16'hff30, 1'b0);
    chk({debug_rom_sel, user_top_hidden}, 2'h3);
    acc(16'hff06, 1'b0);
    chk(debug_reg_sel, 1'b1);
    apb(1'b1, A, 8'h60);
    rdchk(8'h09);
    apb(1'b1, A, 8'h64);
    rdchk(8'h70);
    apb(1'b1, A, 8'h40);
    rdchk(8'h70);
  endtask : special_single

  task automatic peripheral();
    boot(3'b110);
    chk({special_mode_low, mode_select_upper, mode_select_lower}, 3'h2);
    chk(cpu_hold, 1'b1);
    apb(1'b0, A, 8'h00);
    chk({err, rd[7:0]}, 9'h100);
  endtask : peripheral

  task automatic debug_enable();
    boot(3'b100);
    rdchk(8'h90);
    pulse(4'h2);
    chk(background_debug_active, 1'b0);
    pulse(4'h1);
    pulse(4'h4);
    chk(background_debug_active, 1'b1);
    pulse(4'h8);
    pulse(4'h2);
    chk(background_debug_active, 1'b1);
  endtask : debug_enable

  task automatic decode();
    logic [2:0] c [3] = '{3'b001, 3'b011, 3'b111};
    logic [7:0] e [3] = '{8'h39, 8'h79, 8'hf0};
    logic [2:0] f [3] = '{3'h4, 3'h0, 3'h3};
    for (int i = 0; i < 3; i++) begin
      boot(c[i]);
      rdchk(e[i]);
      chk(port_a_gpio, 1'b0);
      acc(16'h0800, 1'b0);
      chk({visible_wide, stretch_low, port_e_mapped}, f[i]);
    end
  endtask : decode

  initial begin
    narrow_normal();
    special_single();
    peripheral();
    debug_enable();
    decode();
    end_sim();
  end
endmodule : operating_mode_control_test
`default_nettype wire
